// >>> include/alarm_pkg.sv
// Shared constants, register map and enumerations for the two-channel alarm block
package alarm_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [3:0] IDX_CONFIG = 4'h0;
  localparam logic [3:0] IDX_MAIN_SETPOINT = 4'h1;
  localparam logic [3:0] IDX_ALARM_ONE_SETPOINT = 4'h2;
  localparam logic [3:0] IDX_ALARM_TWO_SETPOINT = 4'h3;
  localparam logic [3:0] IDX_ALARM_ONE_HYSTERESIS = 4'h4;
  localparam logic [3:0] IDX_ALARM_TWO_HYSTERESIS = 4'h5;
  localparam logic [3:0] IDX_ALARM_ONE_DEVIATION = 4'h6;
  localparam logic [3:0] IDX_ALARM_TWO_DEVIATION = 4'h7;
  localparam logic [3:0] IDX_DWELL_TIME = 4'h8;
  localparam logic [3:0] IDX_INTEGRAL_TIME = 4'h9;
  localparam logic [3:0] IDX_STATUS = 4'hA;
  localparam logic [3:0] IDX_DWELL_ELAPSED = 4'hB;
  localparam logic [3:0] IDX_HEATER_CURRENT = 4'hC;
  localparam int unsigned WRITABLE_COUNT = 10;

  // Configuration register field positions
  localparam int unsigned CFG_FN1_LSB = 0;
  localparam int unsigned CFG_FN2_LSB = 4;
  localparam int unsigned CFG_MD1_LSB = 8;
  localparam int unsigned CFG_MD2_LSB = 10;
  localparam int unsigned CFG_SECOND_OUTPUT_ROLE_ALARM_BIT = 12;
  localparam int unsigned CFG_CT_BIT = 13;
  localparam int unsigned CFG_EVENT_CLEAR_BIT = 14;

  // Reset values
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [15:0] HYSTERESIS_RESET = 16'h0001;

  // Timing: seconds and tenths of a minute at the system clock rate
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SECOND_S = 1;
  localparam int unsigned TENTH_MINUTE_S = 6;
  localparam int unsigned SECOND_CYCLES = SECOND_S * CLK_HZ;
  localparam int unsigned TENTH_MINUTE_CYCLES = TENTH_MINUTE_S * CLK_HZ;
  localparam logic [7:0] LOOP_WINDOW_MAX_S = 8'h78;

  // Signal scales
  localparam logic [15:0] CONTROL_FULL = 16'h03E8;
  localparam logic [15:0] HEATER_CURRENT_MAX = 16'h01F4;

  // Alarm function selections
  typedef enum logic [3:0] {
    FN_NONE, FN_DWELL, FN_PRIMARY_HIGH, FN_PRIMARY_LOW, FN_SECONDARY_HIGH,
    FN_SECONDARY_LOW, FN_EITHER_HIGH, FN_EITHER_LOW, FN_DIFFERENCE_HIGH,
    FN_DIFFERENCE_LOW, FN_DEVIATION_HIGH, FN_DEVIATION_LOW, FN_BAND_HIGH,
    FN_BAND_LOW, FN_LOOP_BREAK
  } alarm_fn_e;

  // Alarm behaviours
  typedef enum logic [1:0] {
    MD_PLAIN, MD_RETAINED, MD_SUPPRESSED, MD_RETAINED_SUPPRESSED
  } alarm_md_e;

  // Dwell timer states
  typedef enum logic [1:0] {DW_WAIT, DW_COUNT, DW_DONE} dwell_state_e;

endpackage

// >>> design/process_alarm_and_dwell_timer.sv
// Two-channel process alarm, dwell timer and loop-break detector with Wishbone registers
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - Dwell timer on one channel only; both raises duplicate-dwell error.
// - Dwell duration 0 to 6553.5 minutes in tenth-minute steps.
// - Dwell count starts from zero when process first reaches set point.
// - Dwell channel output changes only at timeout.
// - A dwell channel ignores its alarm behaviour setting.
// - Second output as alarm with function none raises missing-function error.
// - Eight absolute alarms: primary, secondary, either, difference; high and low.
// - Either alarms take whichever input passes; difference is primary minus secondary.
// - Process thresholds are alarm set point plus and minus half hysteresis.
// - Plain behaviour: output energized while the alarm condition holds.
// - Retained behaviour keeps output energized until reset or event input.
// - Suppressed behaviour blocks alarm after power-up until set point reached.
// - Retained-suppressed combines suppression and retention.
// - Deviation thresholds: set point plus deviation, plus and minus half hysteresis.
// - Deviation high and low types, each usable with all four behaviours.
// - Band thresholds at set point plus and minus deviation, no hysteresis.
// - With current transformer input, heater current reported 0 to 50.0 A.
// - Heater-break alarm unavailable when output one is a linear output.
// - Loop-break window is twice integral time, at most 120 seconds.
// - Loop break when output saturated all window and process fails to follow.
// - Loop-break alarms never apply power-up suppression.
module process_alarm_and_dwell_timer #(
  parameter int unsigned SECOND_CYCLES = alarm_pkg::SECOND_CYCLES,
  parameter int unsigned TENTH_MINUTE_CYCLES = alarm_pkg::TENTH_MINUTE_CYCLES
) (
  input wire logic clk, // System clock, 200 MHz
  input wire logic resetn, // Asynchronous active-low reset
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [15:0] process_value_primary, // Signed primary input, tenths
  input wire logic [15:0] process_value_secondary, // Signed secondary input, tenths
  input wire logic [15:0] control_output_level, // Control output, tenths of percent
  input wire logic output_one_linear, // Output one is a linear output
  input wire logic event_input, // Event input level
  output logic alarm_one_out, // Alarm one energized
  output logic alarm_two_out, // Alarm two energized
  output logic duplicate_dwell_error, // Dwell selected on both channels
  output logic missing_alarm_function_error // Second alarm has no function
);

  logic rst_meta_r;
  logic rst_n;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [15:0] regs_r [alarm_pkg::WRITABLE_COUNT];
  logic [3:0] idx;
  logic access;
  logic mapped;
  logic [15:0] cfg;
  alarm_pkg::alarm_fn_e fn [2];
  alarm_pkg::alarm_md_e md [2];
  logic signed [17:0] pv1x;
  logic signed [17:0] pv2x;
  logic signed [17:0] spx;
  logic ct_mode;
  logic second_output_role_alarm;
  logic latch_clear;
  logic reached_r;
  logic dup_err;
  logic miss_err;
  logic dup_r;
  logic miss_r;
  logic [1:0] raw_r;
  logic [1:0] hb_block;
  logic [1:0] out_r;
  logic [15:0] heater_current;
  // Dwell timer
  alarm_pkg::dwell_state_e dwell_r;
  logic [31:0] tenth_cnt_r;
  logic [15:0] dwell_elapsed_r;
  logic dwell_on1;
  logic dwell_on2;
  logic dwell_out;
  // Loop break
  logic [31:0] sec_cnt_r;
  logic sec_tick;
  logic [7:0] lb_secs_r;
  logic [7:0] lb_window;
  logic signed [17:0] lb_pv_r;
  logic lb_dir_r;
  logic lb_r;
  logic at_max;
  logic at_min;

  // Reset release through two flops
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  assign idx = wb_adr_i[5:2];
  assign access = wb_cyc_i & wb_stb_i & ~ack_r;
  assign mapped = (wb_adr_i[7:6] == 2'b00) && (idx <= alarm_pkg::IDX_HEATER_CURRENT);

  // Ack one cycle after a request, then dropped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= access;
  end

  // Writes use only the two low byte lanes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < alarm_pkg::WRITABLE_COUNT; i++)
        regs_r[i] <= alarm_pkg::VALUE_RESET;
      regs_r[alarm_pkg::IDX_CONFIG] <= alarm_pkg::CONFIG_RESET;
      regs_r[alarm_pkg::IDX_ALARM_ONE_HYSTERESIS] <= alarm_pkg::HYSTERESIS_RESET;
      regs_r[alarm_pkg::IDX_ALARM_TWO_HYSTERESIS] <= alarm_pkg::HYSTERESIS_RESET;
    end
    else if (access && wb_we_i && mapped && idx < 4'(alarm_pkg::WRITABLE_COUNT))
    begin
      if (wb_sel_i[0])
        regs_r[idx][7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        regs_r[idx][15:8] <= wb_dat_i[15:8];
    end
  end

  // Read data registered with ack; unmapped words read zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0;
    else if (access && !mapped)
      rdata_r <= 32'h0;
    else if (access)
    begin
      case (idx)
        alarm_pkg::IDX_STATUS:
          rdata_r <= {25'h0, hb_block[0] | hb_block[1], dwell_r == alarm_pkg::DW_DONE,
                      reached_r, miss_r, dup_r, out_r[1], out_r[0]};
        alarm_pkg::IDX_DWELL_ELAPSED: rdata_r <= {16'h0, dwell_elapsed_r};
        alarm_pkg::IDX_HEATER_CURRENT: rdata_r <= {16'h0, heater_current};
        default: rdata_r <= {16'h0, regs_r[idx]};
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // Configuration decode
  assign cfg = regs_r[alarm_pkg::IDX_CONFIG];
  assign fn[0] = alarm_pkg::alarm_fn_e'(cfg[alarm_pkg::CFG_FN1_LSB +: 4]);
  assign fn[1] = alarm_pkg::alarm_fn_e'(cfg[alarm_pkg::CFG_FN2_LSB +: 4]);
  assign md[0] = alarm_pkg::alarm_md_e'(cfg[alarm_pkg::CFG_MD1_LSB +: 2]);
  assign md[1] = alarm_pkg::alarm_md_e'(cfg[alarm_pkg::CFG_MD2_LSB +: 2]);
  assign second_output_role_alarm = cfg[alarm_pkg::CFG_SECOND_OUTPUT_ROLE_ALARM_BIT];
  assign ct_mode = cfg[alarm_pkg::CFG_CT_BIT];
  assign latch_clear = event_input & cfg[alarm_pkg::CFG_EVENT_CLEAR_BIT];
  assign pv1x = {{2{process_value_primary[15]}}, process_value_primary};
  assign pv2x = {{2{process_value_secondary[15]}}, process_value_secondary};
  assign spx = {{2{regs_r[alarm_pkg::IDX_MAIN_SETPOINT][15]}},
                regs_r[alarm_pkg::IDX_MAIN_SETPOINT]};

  // Configuration errors
  assign dup_err = (fn[0] == alarm_pkg::FN_DWELL) && (fn[1] == alarm_pkg::FN_DWELL);
  assign miss_err = second_output_role_alarm && (fn[1] == alarm_pkg::FN_NONE);

  // Heater current clamps to full scale
  assign heater_current = !ct_mode ? 16'h0 :
    process_value_secondary[15] ? 16'h0 :
    (process_value_secondary > alarm_pkg::HEATER_CURRENT_MAX) ?
    alarm_pkg::HEATER_CURRENT_MAX : process_value_secondary;

  // Error flags follow the configuration each cycle; first arrival at set point held until reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dup_r <= 1'b0;
      miss_r <= 1'b0;
      reached_r <= 1'b0;
    end
    else
    begin
      dup_r <= dup_err;
      miss_r <= miss_err;
      if (pv1x >= spx)
        reached_r <= 1'b1;
    end
  end

  assign duplicate_dwell_error = dup_r;
  assign missing_alarm_function_error = miss_r;

  // Per-channel comparators, hysteresis state and output behaviour
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    logic signed [17:0] v;
    logic signed [17:0] ref_lvl;
    logic signed [17:0] half;
    logic signed [17:0] dv;
    logic signed [17:0] adv;
    logic is_high;
    logic is_band;
    logic raw_nxt;
    logic enabled;
    logic armed;
    logic cond;
    logic retain;
    logic out_nxt;

    assign dv = {{2{regs_r[alarm_pkg::IDX_ALARM_ONE_DEVIATION + ch][15]}},
                 regs_r[alarm_pkg::IDX_ALARM_ONE_DEVIATION + ch]};
    assign adv = dv[17] ? -dv : dv;
    assign half = 18'($unsigned(regs_r[alarm_pkg::IDX_ALARM_ONE_HYSTERESIS + ch]) >> 1);
    assign hb_block[ch] = ct_mode && output_one_linear &&
      (fn[ch] == alarm_pkg::FN_SECONDARY_HIGH || fn[ch] == alarm_pkg::FN_SECONDARY_LOW);

    // Compared value, reference and alarm sense
    always_comb
    begin
      v = pv1x;
      ref_lvl = {{2{regs_r[alarm_pkg::IDX_ALARM_ONE_SETPOINT + ch][15]}},
                 regs_r[alarm_pkg::IDX_ALARM_ONE_SETPOINT + ch]};
      is_high = 1'b1;
      is_band = 1'b0;
      case (fn[ch])
        alarm_pkg::FN_PRIMARY_LOW: is_high = 1'b0;
        alarm_pkg::FN_SECONDARY_HIGH: v = pv2x;
        alarm_pkg::FN_SECONDARY_LOW:
        begin
          v = pv2x;
          is_high = 1'b0;
        end
        alarm_pkg::FN_EITHER_HIGH: v = (pv1x > pv2x) ? pv1x : pv2x;
        alarm_pkg::FN_EITHER_LOW:
        begin
          v = (pv1x < pv2x) ? pv1x : pv2x;
          is_high = 1'b0;
        end
        alarm_pkg::FN_DIFFERENCE_HIGH: v = pv1x - pv2x;
        alarm_pkg::FN_DIFFERENCE_LOW:
        begin
          v = pv1x - pv2x;
          is_high = 1'b0;
        end
        alarm_pkg::FN_DEVIATION_HIGH: ref_lvl = spx + dv;
        alarm_pkg::FN_DEVIATION_LOW:
        begin
          ref_lvl = spx + dv;
          is_high = 1'b0;
        end
        alarm_pkg::FN_BAND_HIGH: is_band = 1'b1;
        alarm_pkg::FN_BAND_LOW:
        begin
          is_band = 1'b1;
          is_high = 1'b0;
        end
        default: ;
      endcase
    end

    // Hysteresis holds state between the thresholds
    always_comb
    begin
      if (fn[ch] == alarm_pkg::FN_LOOP_BREAK)
        raw_nxt = lb_r;
      else if (is_band)
        raw_nxt = ((v > spx + adv) || (v < spx - adv)) == is_high;
      else if (is_high ? (v > ref_lvl + half) : (v < ref_lvl - half))
        raw_nxt = 1'b1;
      else if (is_high ? (v < ref_lvl - half) : (v > ref_lvl + half))
        raw_nxt = 1'b0;
      else
        raw_nxt = raw_r[ch];
    end

    assign enabled = (ch == 0 || second_output_role_alarm) && !hb_block[ch] && fn[ch] != alarm_pkg::FN_NONE
                     && fn[ch] != alarm_pkg::FN_DWELL;
    assign armed = reached_r || fn[ch] == alarm_pkg::FN_LOOP_BREAK ||
                   md[ch] == alarm_pkg::MD_PLAIN || md[ch] == alarm_pkg::MD_RETAINED;
    assign cond = enabled && armed && raw_r[ch];
    assign retain = md[ch] == alarm_pkg::MD_RETAINED ||
                    md[ch] == alarm_pkg::MD_RETAINED_SUPPRESSED;
    // A new alarm beats a simultaneous event-input clear
    assign out_nxt = (fn[ch] == alarm_pkg::FN_DWELL && (ch == 0 || second_output_role_alarm)) ?
                     dwell_out :
                     retain ? (cond | (out_r[ch] & enabled & ~latch_clear)) : cond;

    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        raw_r[ch] <= 1'b0;
        out_r[ch] <= 1'b0;
      end
      else
      begin
        raw_r[ch] <= raw_nxt;
        out_r[ch] <= out_nxt;
      end
    end
  end

  assign alarm_one_out = out_r[0];
  assign alarm_two_out = out_r[1];

  // Dwell timer needs a single owner channel
  assign dwell_on1 = fn[0] == alarm_pkg::FN_DWELL;
  assign dwell_on2 = fn[1] == alarm_pkg::FN_DWELL;
  assign dwell_out = dwell_r == alarm_pkg::DW_DONE;

  // Counting runs in tenth-minute ticks; a zero duration times out on arrival
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dwell_r <= alarm_pkg::DW_WAIT;
      tenth_cnt_r <= 32'h0;
      dwell_elapsed_r <= 16'h0;
    end
    else if (!(dwell_on1 ^ dwell_on2))
    begin
      dwell_r <= alarm_pkg::DW_WAIT;
      tenth_cnt_r <= 32'h0;
      dwell_elapsed_r <= 16'h0;
    end
    else
    begin
      case (dwell_r)
        alarm_pkg::DW_WAIT:
          if (reached_r)
          begin
            dwell_r <= alarm_pkg::DW_COUNT;
            tenth_cnt_r <= 32'h0;
            dwell_elapsed_r <= 16'h0;
          end
        alarm_pkg::DW_COUNT:
          if (dwell_elapsed_r >= regs_r[alarm_pkg::IDX_DWELL_TIME])
            dwell_r <= alarm_pkg::DW_DONE;
          else if (tenth_cnt_r == TENTH_MINUTE_CYCLES - 1)
          begin
            tenth_cnt_r <= 32'h0;
            dwell_elapsed_r <= dwell_elapsed_r + 16'h1;
          end
          else
            tenth_cnt_r <= tenth_cnt_r + 32'h1;
        alarm_pkg::DW_DONE: ;
        default: dwell_r <= alarm_pkg::DW_WAIT;
      endcase
    end
  end

  // One-second tick for loop-break windows
  assign sec_tick = sec_cnt_r == SECOND_CYCLES - 1;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sec_cnt_r <= 32'h0;
    else if (sec_tick)
      sec_cnt_r <= 32'h0;
    else
      sec_cnt_r <= sec_cnt_r + 32'h1;
  end

  // Window is twice integral time in seconds, capped; zero disables detection
  assign lb_window =
    (regs_r[alarm_pkg::IDX_INTEGRAL_TIME] >= 16'(alarm_pkg::LOOP_WINDOW_MAX_S >> 1)) ?
    alarm_pkg::LOOP_WINDOW_MAX_S :
    {regs_r[alarm_pkg::IDX_INTEGRAL_TIME][6:0], 1'b0};
  assign at_max = control_output_level >= alarm_pkg::CONTROL_FULL;
  assign at_min = control_output_level == 16'h0;

  // Saturation must last the whole window; leaving it restarts and clears
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lb_secs_r <= 8'h00;
      lb_pv_r <= 18'sh0;
      lb_dir_r <= 1'b0;
      lb_r <= 1'b0;
    end
    else if (lb_window == 8'h00 || !(at_max || at_min) || lb_dir_r != at_max)
    begin
      lb_secs_r <= 8'h00;
      lb_pv_r <= pv1x;
      lb_dir_r <= at_max;
      lb_r <= 1'b0;
    end
    else if (sec_tick)
    begin
      if (lb_secs_r + 8'h01 >= lb_window)
      begin
        lb_secs_r <= 8'h00;
        lb_pv_r <= pv1x;
        lb_r <= lb_dir_r ? (pv1x <= lb_pv_r) : (pv1x >= lb_pv_r);
      end
      else
        lb_secs_r <= lb_secs_r + 8'h01;
    end
  end

endmodule

// >>> sim/alarm_checks_asserts.sv
// Port-level checker for the alarm block, bound to its top module
`timescale 1ns/1ps
module alarm_checks (
  input wire logic clk, // Clock
  input wire logic resetn, // Active-low reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [7:0] wb_adr_i, // Bus address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic [15:0] process_value_primary, // Primary input
  input wire logic [15:0] process_value_secondary, // Secondary input
  input wire logic [15:0] control_output_level, // Control output
  input wire logic output_one_linear, // Linear output flag
  input wire logic event_input, // Event input
  input wire logic alarm_one_out, // Alarm one
  input wire logic alarm_two_out, // Alarm two
  input wire logic duplicate_dwell_error, // Dwell chosen twice
  input wire logic missing_alarm_function_error // Alarm two lacks a function
);
  logic [15:0] cfg_r;
  logic dup_sel, miss_sel, hold1, dw1;

  // Shadow of the configuration word
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cfg_r <= 16'h0000;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00)
    begin
      if (wb_sel_i[0])
        cfg_r[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        cfg_r[15:8] <= wb_dat_i[15:8];
    end
  end

  // Decoded selections; hold1 excludes event clearing
  assign dup_sel = cfg_r[3:0] == 4'h1 && cfg_r[7:4] == 4'h1;
  assign miss_sel = cfg_r[12] && cfg_r[7:4] == 4'h0;
  assign hold1 = cfg_r[9:8] == 2'h1 && cfg_r[3:1] != 3'h0 && cfg_r[3:1] != 3'h2
                 && !(event_input && cfg_r[14]);
  assign dw1 = cfg_r[3:0] == 4'h1 && cfg_r[7:4] != 4'h1;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Multi-step behaviours
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence retained_s;
    hold1 [*3] ##0 alarm_one_out;
  endsequence
  sequence dwell_on_s;
    dw1 [*2] ##0 alarm_one_out;
  endsequence

  ack_next_a: assert property (req_s |=> wb_ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  unmapped_zero_a: assert property (req_s ##0 (!wb_we_i && wb_adr_i[7:6] != 2'h0)
    |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  dup_error_a: assert property ($stable(dup_sel) [*3] |-> duplicate_dwell_error == dup_sel)
    else $error("duplicate dwell flag wrong");
  dup_quiet_a: assert property (dup_sel [*4] |-> !alarm_one_out && !alarm_two_out)
    else $error("dwell ran with duplicate selection");
  miss_error_a: assert property ($stable(miss_sel) [*3] |->
    missing_alarm_function_error == miss_sel)
    else $error("missing function flag wrong");
  two_off_a: assert property (!cfg_r[12] [*3] |-> !alarm_two_out)
    else $error("alarm two active while not an alarm");
  retained_keep_a: assert property (retained_s |=> alarm_one_out)
    else $error("retained alarm dropped");
  dwell_keep_a: assert property (dwell_on_s |=> alarm_one_out)
    else $error("dwell output changed after timeout");
endmodule

bind process_alarm_and_dwell_timer alarm_checks chk_u (.clk(clk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .process_value_primary(process_value_primary),
  .process_value_secondary(process_value_secondary),
  .control_output_level(control_output_level), .output_one_linear(output_one_linear),
  .event_input(event_input), .alarm_one_out(alarm_one_out), .alarm_two_out(alarm_two_out),
  .duplicate_dwell_error(duplicate_dwell_error),
  .missing_alarm_function_error(missing_alarm_function_error));

// >>> sim/process_side_model.sv
// Behavioural stand-in for the process sensors and control output
`timescale 1ns/1ps
module process_side_model (
  input wire logic clk, // Bench clock
  output logic [15:0] pv1, // Primary process value
  output logic [15:0] pv2, // Secondary value or heater current
  output logic [15:0] ctrl, // Control output level
  output logic linear, // Output one is linear
  output logic event_in // Event input level
);
  // Quiet start: all readings zero, no event
  initial
  begin
    pv1 = 16'h0000;
    pv2 = 16'h0000;
    ctrl = 16'h0000;
    linear = 1'b0;
    event_in = 1'b0;
  end

  // Readings change just after an edge and then stay put
  task put(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    pv1 <= a;
    pv2 <= b;
  endtask

  // Control output, output type and event input
  task aux(input logic [15:0] c, input logic l, input logic e);
    @(posedge clk);
    ctrl <= c;
    linear <= l;
    event_in <= e;
  endtask
endmodule

// >>> sim/tb_process_alarm_and_dwell_timer.sv
// Self-checking bench for the alarm and dwell timer block
`timescale 1ns/1ps
module tb_process_alarm_and_dwell_timer;
  logic clk, resetn, cyc, stb, we, ack, a1, a2, e_dup, e_miss, lin, ev;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q;
  logic [15:0] pv1, pv2, ctrl;
  int err_count = 0;
  int n_checks = 0;
  int cyc_n = 0;

  // Short counts keep windows brief
  process_alarm_and_dwell_timer #(.SECOND_CYCLES(10), .TENTH_MINUTE_CYCLES(20)) uut (
    .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .process_value_primary(pv1), .process_value_secondary(pv2),
    .control_output_level(ctrl), .output_one_linear(lin), .event_input(ev),
    .alarm_one_out(a1), .alarm_two_out(a2), .duplicate_dwell_error(e_dup),
    .missing_alarm_function_error(e_miss));
  process_side_model m (.clk(clk), .pv1(pv1), .pv2(pv2), .ctrl(ctrl), .linear(lin),
    .event_in(ev));

  // Free-running 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Ceiling far past the real run catches a hang
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000)
    begin
      err_count++;
      end_sim();
    end
  end

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Hold the request until ack, take data at that edge
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0000, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task wr(input logic [3:0] i, input logic [15:0] d);
    bus(1'b1, {2'b00, i, 2'b00}, d);
  endtask

  task rd(input logic [3:0] i);
    bus(1'b0, {2'b00, i, 2'b00}, 16'h0000);
  endtask

  // Outputs settle within three cycles of an input change
  task exp2(input logic e1, input logic e2);
    repeat (4) @(posedge clk);
    chk(a1, e1);
    chk(a2, e2);
  endtask

  // Reset held 16 cycles, then room for the release
  task rst;
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task t_regs;
    rd(alarm_pkg::IDX_CONFIG);
    chk(q, alarm_pkg::CONFIG_RESET);
    rd(alarm_pkg::IDX_ALARM_ONE_HYSTERESIS);
    chk(q, alarm_pkg::HYSTERESIS_RESET);
    bus(1'b1, 8'h40, 16'hFFFF);
    bus(1'b0, 8'h40, 16'h0000);
    chk(q, 32'h0);
    wr(4'hB, 16'hFFFF);
    rd(4'hB);
    chk(q, 32'h0);
    wr(4'h1, 16'h1234);
    rd(4'h1);
    chk(q, 32'h1234);
    $display("register test done");
  endtask

  task t_absolute;
    logic [15:0] t [0:7][0:3] = '{'{16'h0, 16'h0, 16'h6E, 16'h0}, '{16'h6E, 16'h0, 16'h5A, 16'h0},
      '{16'h0, 16'h0, 16'h0, 16'h6E}, '{16'h0, 16'h6E, 16'h0, 16'h5A},
      '{16'h0, 16'h0, 16'h0, 16'h6E}, '{16'h6E, 16'h6E, 16'h6E, 16'h5A},
      '{16'h6E, 16'h6E, 16'hDC, 16'h64}, '{16'hDC, 16'h64, 16'h6E, 16'h6E}};
    logic [3:0] f;
    wr(4'h2, 16'h0064);
    wr(4'h3, 16'h0064);
    wr(4'h4, 16'h000A);
    wr(4'h5, 16'h000A);
    for (int i = 0; i < 8; i++)
    begin
      f = 4'(i + 2);
      wr(4'h0, {3'h0, 1'b1, 4'h0, f, f});
      m.put(t[i][0], t[i][1]);
      exp2(1'b0, 1'b0);
      chk(e_miss, 1'b0);
      m.put(t[i][2], t[i][3]);
      exp2(1'b1, 1'b1);
    end
    wr(4'h0, 16'h1022);
    m.put(16'h005E, 16'h0000);
    exp2(1'b0, 1'b0);
    m.put(16'h006A, 16'h0000);
    exp2(1'b1, 1'b1);
    m.put(16'h005F, 16'h0000);
    exp2(1'b1, 1'b1);
    m.put(16'h005E, 16'h0000);
    exp2(1'b0, 1'b0);
    $display("absolute alarm test done");
  endtask

  task t_dev_band;
    wr(4'h1, 16'h0064);
    wr(4'h6, 16'h0014);
    wr(4'h7, 16'hFFEC);
    wr(4'h0, 16'h51BA);
    m.put(16'h007E, 16'h0000);
    exp2(1'b1, 1'b0);
    m.put(16'h004A, 16'h0000);
    exp2(1'b1, 1'b1);
    m.put(16'h0064, 16'h0000);
    exp2(1'b1, 1'b0);
    m.aux(16'h0000, 1'b0, 1'b1);
    exp2(1'b0, 1'b0);
    m.aux(16'h0000, 1'b0, 1'b0);
    wr(4'h6, 16'h0005);
    wr(4'h7, 16'h0005);
    wr(4'h0, 16'h10DC);
    m.put(16'h006A, 16'h0000);
    exp2(1'b1, 1'b0);
    m.put(16'h0069, 16'h0000);
    exp2(1'b0, 1'b1);
    m.put(16'h005E, 16'h0000);
    exp2(1'b1, 1'b0);
    $display("deviation and band test done");
  endtask

  task t_hold;
    m.put(16'h8000, 16'h0000);
    rst();
    wr(4'h1, 16'h012C);
    wr(4'h2, 16'h0064);
    wr(4'h3, 16'h0064);
    wr(4'h4, 16'h000A);
    wr(4'h5, 16'h000A);
    wr(4'h0, 16'h1E22);
    m.put(16'h00C8, 16'h0000);
    exp2(1'b0, 1'b0);
    m.put(16'h012C, 16'h0000);
    exp2(1'b1, 1'b1);
    m.put(16'h0000, 16'h0000);
    exp2(1'b0, 1'b1);
    $display("holding test done");
  endtask

  task t_dwell;
    m.put(16'h8000, 16'h0000);
    rst();
    wr(4'h1, 16'h0064);
    wr(4'h8, 16'h0002);
    wr(4'h0, 16'h4101);
    m.put(16'h0064, 16'h0000);
    repeat (25) @(posedge clk);
    chk(a1, 1'b0);
    repeat (35) @(posedge clk);
    chk(a1, 1'b1);
    m.aux(16'h0000, 1'b0, 1'b1);
    m.put(16'h0000, 16'h0000);
    exp2(1'b1, 1'b0);
    m.aux(16'h0000, 1'b0, 1'b0);
    wr(4'h0, 16'h1011);
    exp2(1'b0, 1'b0);
    chk(e_dup, 1'b1);
    wr(4'h0, 16'h1000);
    exp2(1'b0, 1'b0);
    chk(e_miss, 1'b1);
    chk(e_dup, 1'b0);
    $display("dwell test done");
  endtask

  task t_loop_heater;
    wr(4'h9, 16'h0003);
    wr(4'h0, 16'h000E);
    m.aux(16'h03E8, 1'b0, 1'b0);
    repeat (50) @(posedge clk);
    chk(a1, 1'b0);
    for (int k = 0; k < 40 && a1 !== 1'b1; k++)
      @(posedge clk);
    chk(a1, 1'b1);
    m.aux(16'h01F4, 1'b0, 1'b0);
    exp2(1'b0, 1'b0);
    wr(4'h2, 16'h0064);
    wr(4'h0, 16'h2005);
    m.put(16'h0000, 16'h0258);
    rd(alarm_pkg::IDX_HEATER_CURRENT);
    chk(q, alarm_pkg::HEATER_CURRENT_MAX);
    m.put(16'h0000, 16'h007B);
    rd(alarm_pkg::IDX_HEATER_CURRENT);
    chk(q, 32'h7B);
    m.put(16'h0000, 16'h0000);
    exp2(1'b1, 1'b0);
    m.aux(16'h01F4, 1'b1, 1'b0);
    exp2(1'b0, 1'b0);
    $display("loop break and heater test done");
  endtask

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h3;
    adr = 8'h00;
    dat = 32'h0;
    rst();
    t_regs();
    t_absolute();
    t_dev_band();
    t_hold();
    t_dwell();
    t_loop_heater();
    end_sim();
  end
endmodule
